// ===== logic/hsss_pkg.sv
// Constants, register map and state type of the hot-swap slot sequencer
package hsss_pkg;

  // Clock and power-on reset timing
  localparam int unsigned CLK_HZ  = 40_000_000;
  localparam int unsigned POR_US  = 500;
  localparam int unsigned POR_CYC = POR_US * (CLK_HZ / 1_000_000);

  // Register word offsets (byte address bits [7:2])
  localparam logic [5:0] CTRL_A_IDX = 6'h00;
  localparam logic [5:0] CTRL_B_IDX = 6'h01;
  localparam logic [5:0] STAT_A_IDX = 6'h02;
  localparam logic [5:0] STAT_B_IDX = 6'h03;
  localparam logic [5:0] COMM_IDX   = 6'h04;

  // Control register fields
  localparam int unsigned CTL_MAIN_BIT = 0;
  localparam int unsigned CTL_AUX_BIT  = 1;

  // Slot status register fields
  localparam int unsigned ST_UVF_BIT   = 0;
  localparam int unsigned ST_MAIN_BIT  = 1;
  localparam int unsigned ST_AUX_BIT   = 2;
  localparam int unsigned ST_FLT_BIT   = 3;

  // Common status register fields
  localparam int unsigned CM_SBY_BIT   = 0;
  localparam int unsigned CM_MASK_BIT  = 3;
  localparam int unsigned CM_GPI_LSB   = 4;

  typedef enum logic {
    SLOT_OFF,
    SLOT_ON
  } hsss_slot_st_t;

  typedef struct packed {
    hsss_slot_st_t [1:0] slot;
    logic [1:0]          ctl_main;
    logic [1:0]          ctl_aux;
    logic [1:0]          uv_flt;
    logic [1:0]          hw_flt;
    logic                sby;
    logic                int_mask;
    logic                smi_off;
    logic [1:0]          main_en;
    logic [1:0]          pulldn;
    logic [1:0]          disch;
    logic [1:0]          aux_en;
    logic [1:0]          fault_n;
    logic                int_n;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } hsss_st_t;

  // Safe state: slots off, gates pulled down, discharge on, flags idle
  localparam hsss_st_t ST_RST = '{
    slot:     '{SLOT_OFF, SLOT_OFF},
    ctl_main: 2'h0,
    ctl_aux:  2'h0,
    uv_flt:   2'h0,
    hw_flt:   2'h0,
    sby:      1'b0,
    int_mask: 1'b0,
    smi_off:  1'b0,
    main_en:  2'h0,
    pulldn:   2'h3,
    disch:    2'h3,
    aux_en:   2'h0,
    fault_n:  2'h3,
    int_n:    1'b1,
    pready:   1'b0,
    pslverr:  1'b0,
    prdata:   32'h0
  };

endpackage

// ===== logic/hsss_req_sync.sv
// Two-flop synchroniser with rising-edge detect for request inputs
`timescale 1ns/1ps
`default_nettype none
module hsss_req_sync #(
  parameter int unsigned W = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // Raw and conditioned requests
  input  wire logic [W-1:0] req_in,
  output logic      [W-1:0] req_lvl,
  output logic      [W-1:0] req_rise
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // Edge detect looks only at the second stage, never the first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= req_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign req_lvl  = sync_r;
  assign req_rise = sync_r & ~prev_r;

endmodule
`default_nettype wire

// ===== logic/hsss_por_timer.sv
// Standby-supply qualification timer producing the power-on reset done level
`timescale 1ns/1ps
`default_nettype none
module hsss_por_timer #(
  parameter int unsigned CYC = hsss_pkg::POR_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Supply monitor and result
  input  wire logic stby_ok,
  output logic      por_done
);

  localparam int unsigned CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] CMAX = CW'(CYC);

  logic [CW-1:0] cnt_r;
  logic          done_r;

  // Any dropout restarts the full interval
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else if (!stby_ok) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else if (cnt_r != CMAX) begin
      cnt_r  <= cnt_r + CW'(1);
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b1;
    end
  end

  assign por_done = done_r;

endmodule
`default_nettype wire

// ===== logic/hsss_top.sv
// Dual-slot hot-swap power sequencer with hardware pins and APB registers
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Hardware request pins and management registers per slot
// - Pins low leaves power to registers only
// - Strap disables management access entirely
// - Host reads slot faults and input pins
// - End reset after 500 us valid standby
// - Clear every register when reset completes
// - Standby dropout restarts the whole reset
// - Bus answers with an error until reset interval ends
// - Enables off, pull-downs and discharge on during reset interval
// - Main rising edge turns on if supplies good
// - Gate pull-downs active while slot off
// - Discharge switches on when slot off
// - Enabled main undervoltage enters standby
// - Aux enabled by pin or register bit
// - Aux ignores main undervoltage
// - Undervoltage while requested raises fault, interrupt
// - Writing one to fault bit releases interrupt
module hsss_top #(
  parameter int unsigned POR_CYC = hsss_pkg::POR_CYC
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Supply monitors and straps
  input  wire logic        STBY_OK,
  input  wire logic [1:0]  MAIN_UV_OK,
  input  wire logic        SMI_STRAP_OFF,
  input  wire logic [1:0]  GPI,
  // Hardware power port
  input  wire logic [1:0]  MAIN_REQ,
  input  wire logic [1:0]  AUX_REQ,
  output logic      [1:0]  SLOT_FAULT_N,
  // Slot outputs
  output logic      [1:0]  MAIN_EN,
  output logic      [1:0]  GATE_PULLDN,
  output logic      [1:0]  DISCHARGE,
  output logic      [1:0]  AUX_EN,
  // Management interrupt
  output logic             INT_N
);

  hsss_pkg::hsss_st_t r;
  hsss_pkg::hsss_st_t n;

  logic       por_done;
  logic [1:0] main_lvl;
  logic [1:0] main_rise;
  logic [1:0] aux_lvl;

  hsss_por_timer #(
    .CYC (POR_CYC)
  ) u_por (
    .clk      (CLK),
    .arst_n   (ARST_N),
    .stby_ok  (STBY_OK),
    .por_done (por_done)
  );

  hsss_req_sync #(
    .W (2)
  ) u_main_sync (
    .clk      (CLK),
    .arst_n   (ARST_N),
    .req_in   (MAIN_REQ),
    .req_lvl  (main_lvl),
    .req_rise (main_rise)
  );

  hsss_req_sync #(
    .W (2)
  ) u_aux_sync (
    .clk      (CLK),
    .arst_n   (ARST_N),
    .req_in   (AUX_REQ),
    .req_lvl  (aux_lvl),
    .req_rise ()
  );

  // Bus decode
  logic       acc;
  logic       bus_ok;
  logic       mapped;
  logic       wr;
  logic [5:0] idx;

  assign idx    = PADDR[7:2];
  assign acc    = PSEL & PENABLE & ~r.pready;
  assign bus_ok = por_done & ~r.smi_off;
  assign mapped = (PADDR[1:0] == 2'h0) &&
                  (idx == hsss_pkg::CTRL_A_IDX || idx == hsss_pkg::CTRL_B_IDX ||
                   idx == hsss_pkg::STAT_A_IDX || idx == hsss_pkg::STAT_B_IDX ||
                   idx == hsss_pkg::COMM_IDX);
  assign wr     = acc & PWRITE & bus_ok & mapped;

  // Read mux
  logic [31:0] rdata;

  always_comb begin
    rdata = 32'h0;
    case (idx)
      hsss_pkg::CTRL_A_IDX, hsss_pkg::CTRL_B_IDX: begin
        rdata[hsss_pkg::CTL_MAIN_BIT] = r.ctl_main[idx[0]];
        rdata[hsss_pkg::CTL_AUX_BIT]  = r.ctl_aux[idx[0]];
      end
      hsss_pkg::STAT_A_IDX, hsss_pkg::STAT_B_IDX: begin
        rdata[hsss_pkg::ST_UVF_BIT]  = r.uv_flt[idx[0]];
        rdata[hsss_pkg::ST_MAIN_BIT] = r.main_en[idx[0]];
        rdata[hsss_pkg::ST_AUX_BIT]  = r.aux_en[idx[0]];
        rdata[hsss_pkg::ST_FLT_BIT]  = r.hw_flt[idx[0]];
      end
      hsss_pkg::COMM_IDX: begin
        rdata[hsss_pkg::CM_SBY_BIT]  = r.sby;
        rdata[hsss_pkg::CM_MASK_BIT] = r.int_mask;
        rdata[hsss_pkg::CM_GPI_LSB +: 2] = GPI;
      end
      default: begin
        rdata = 32'h0;
      end
    endcase
  end

  // Next-state logic
  logic [1:0] ctl_rise;
  logic [1:0] req_any;
  logic [1:0] uv_set;
  logic [1:0] uv_clr;
  logic       sby_set;

  always_comb begin
    n        = r;
    ctl_rise = 2'h0;
    req_any  = 2'h0;
    uv_set   = 2'h0;
    uv_clr   = 2'h0;
    sby_set  = 1'b0;

    // Single-cycle answer, held for exactly one cycle
    n.pready  = acc;
    n.pslverr = acc & ~(bus_ok & mapped);
    if (acc && !PWRITE) begin
      n.prdata = (bus_ok && mapped) ? rdata : 32'h0;
    end

    // Register writes; power bits are ORed with the pin levels, so either one keeps a slot on
    if (wr) begin
      case (idx)
        hsss_pkg::CTRL_A_IDX, hsss_pkg::CTRL_B_IDX: begin
          n.ctl_main[idx[0]] = PWDATA[hsss_pkg::CTL_MAIN_BIT];
          n.ctl_aux[idx[0]]  = PWDATA[hsss_pkg::CTL_AUX_BIT];
        end
        hsss_pkg::STAT_A_IDX, hsss_pkg::STAT_B_IDX: begin
          uv_clr[idx[0]] = PWDATA[hsss_pkg::ST_UVF_BIT];
        end
        hsss_pkg::COMM_IDX: begin
          n.int_mask = PWDATA[hsss_pkg::CM_MASK_BIT];
        end
        default: begin
          n.int_mask = r.int_mask;
        end
      endcase
    end

    for (int i = 0; i < 2; i++) begin
      ctl_rise[i] = n.ctl_main[i] & ~r.ctl_main[i];
      req_any[i]  = main_lvl[i] | r.ctl_main[i];
      case (r.slot[i])
        hsss_pkg::SLOT_OFF: begin
          if ((main_rise[i] || ctl_rise[i]) && MAIN_UV_OK[i]) begin
            n.slot[i] = hsss_pkg::SLOT_ON;
          end
        end
        hsss_pkg::SLOT_ON: begin
          if (!MAIN_UV_OK[i]) begin
            n.slot[i] = hsss_pkg::SLOT_OFF;
            sby_set   = 1'b1;
            uv_set[i] = req_any[i];
          end else if (!req_any[i]) begin
            n.slot[i] = hsss_pkg::SLOT_OFF;
          end
        end
        default: begin
          n.slot[i] = hsss_pkg::SLOT_OFF;
        end
      endcase

      // Set wins over a same-cycle clear
      n.uv_flt[i] = (r.uv_flt[i] & ~uv_clr[i]) | uv_set[i];
      // Pin-side fault only for pin-driven slots; cleared by dropping the pins
      if (uv_set[i] && main_lvl[i]) begin
        n.hw_flt[i] = 1'b1;
      end else if (!main_lvl[i] && !aux_lvl[i]) begin
        n.hw_flt[i] = 1'b0;
      end

      n.main_en[i] = (n.slot[i] == hsss_pkg::SLOT_ON);
      n.pulldn[i]  = ~n.main_en[i];
      n.disch[i]   = ~n.main_en[i];
      // Aux runs from standby alone, untouched by main undervoltage
      n.aux_en[i]  = aux_lvl[i] | n.ctl_aux[i];
      n.fault_n[i] = ~n.hw_flt[i];
    end

    n.sby   = sby_set | (r.sby & ~(&MAIN_UV_OK));
    n.int_n = ~((|n.uv_flt) & ~n.int_mask);

    // Until the interval ends everything but the strap latch and the bus answer sits in the safe state
    if (!por_done) begin
      n         = hsss_pkg::ST_RST;
      n.smi_off = SMI_STRAP_OFF;
      n.pready  = acc;
      n.pslverr = acc;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      r <= hsss_pkg::ST_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign PRDATA       = r.prdata;
  assign PREADY       = r.pready;
  assign PSLVERR      = r.pslverr;
  assign SLOT_FAULT_N = r.fault_n;
  assign MAIN_EN      = r.main_en;
  assign GATE_PULLDN  = r.pulldn;
  assign DISCHARGE    = r.disch;
  assign AUX_EN       = r.aux_en;
  assign INT_N        = r.int_n;

endmodule
`default_nettype wire

// ===== verification/hsss_chk.sv
// Port checker for the hot-swap slot sequencer
`timescale 1ns/1ps
`default_nettype none
module hsss_chk (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       ARST_N,
  // Observed ports
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic       PREADY,
  input wire logic       PSLVERR,
  input wire logic       STBY_OK,
  input wire logic [1:0] MAIN_UV_OK,
  input wire logic [1:0] MAIN_EN,
  input wire logic [1:0] GATE_PULLDN,
  input wire logic [1:0] DISCHARGE,
  input wire logic [1:0] AUX_EN,
  input wire logic [1:0] SLOT_FAULT_N,
  input wire logic       INT_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  a_gate_pull_off: assert property (GATE_PULLDN == ~MAIN_EN)
    else $error("gate pull-down wrong");
  a_disch_when_off: assert property (DISCHARGE == ~MAIN_EN)
    else $error("discharge wrong");
  a_uv_drops_main: assert property ((MAIN_EN & ~MAIN_UV_OK) != 2'h0 |=>
    (MAIN_EN & ~$past(MAIN_UV_OK)) == 2'h0) else $error("main kept on in undervoltage");
  a_fault_has_cause: assert property ($fell(SLOT_FAULT_N[1]) |->
    $past(MAIN_EN[1] && !MAIN_UV_OK[1])) else $error("slot fault without cause");
  a_int_has_cause: assert property ($fell(INT_N) |-> $past(MAIN_UV_OK) != 2'h3)
    else $error("interrupt without cause");
  a_on_needs_uv: assert property ($rose(MAIN_EN[0]) |-> $past(MAIN_UV_OK[0]))
    else $error("turn-on in undervoltage");
  a_por_keeps_off: assert property (!STBY_OK |-> ##3 (MAIN_EN == 2'h0 && AUX_EN == 2'h0))
    else $error("output on during reset interval");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_ready_next: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  cover property ($fell(INT_N));
  cover property ($rose(MAIN_EN[1]));
  cover property (PSLVERR);
endmodule
bind hsss_top hsss_chk i_hsss_chk (.CLK, .ARST_N, .PSEL, .PENABLE, .PREADY, .PSLVERR, .STBY_OK,
  .MAIN_UV_OK, .MAIN_EN, .GATE_PULLDN, .DISCHARGE, .AUX_EN, .SLOT_FAULT_N, .INT_N);
`default_nettype wire

// ===== verification/hsss_hpc_model.sv
// Hot-plug controller model driving the hardware request pins
`timescale 1ns/1ps
`default_nettype none
module hsss_hpc_model (
  // Clock
  input wire logic       CLK,
  // Request pins
  output var logic [1:0] MAIN_REQ,
  output var logic [1:0] AUX_REQ
);
  initial begin
    MAIN_REQ = 2'h0;
    AUX_REQ = 2'h0;
  end
  // Levels stand five cycles, so the synchroniser never misses one
  task automatic drive(input logic [1:0] m, input logic [1:0] x);
    @(posedge CLK);
    MAIN_REQ <= m;
    AUX_REQ <= x;
    repeat (5) @(posedge CLK);
  endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the hot-swap slot sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned PC = 20;
  typedef struct packed {
    logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic err;
  } hsss_row_t;
  logic        CLK = 1'b0, ARST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, q;
  logic        PREADY, PSLVERR, INT_N, e, STBY_OK = 1'b1, SMI_STRAP_OFF = 1'b0;
  logic [1:0]  MAIN_UV_OK = 2'h3, GPI = 2'h2, MAIN_REQ, AUX_REQ, SLOT_FAULT_N;
  logic [1:0]  MAIN_EN, GATE_PULLDN, DISCHARGE, AUX_EN;
  int          miscompares = 0, n_compared = 0, cyc = 0;
  hsss_row_t   rows [9] = '{
    '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h00, 32'h2, 32'h0, 1'b0},
    '{1'b0, 8'h00, 32'h0, 32'h2, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h4, 1'b0},
    '{1'b0, 8'h10, 32'h0, 32'h20, 1'b0}, '{1'b1, 8'h0c, 32'hf, 32'h0, 1'b0},
    '{1'b0, 8'h0c, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1},
    '{1'b0, 8'h01, 32'h0, 32'h0, 1'b1}};
  hsss_top #(.POR_CYC(PC)) i_hsss_top (.CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .STBY_OK, .MAIN_UV_OK, .SMI_STRAP_OFF, .GPI,
    .MAIN_REQ, .AUX_REQ, .SLOT_FAULT_N, .MAIN_EN, .GATE_PULLDN, .DISCHARGE, .AUX_EN, .INT_N);
  hsss_hpc_model i_hsss_hpc_model (.CLK, .MAIN_REQ, .AUX_REQ);
  always #12.5 CLK = ~CLK;
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    n_compared++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, g, x);
    end
  endtask
  // Request held until ready is sampled; the slave sets the pace
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rst();
    ARST_N <= 1'b0;
    repeat (5) @(posedge CLK);
    ARST_N <= 1'b1;
  endtask
  initial begin
    rst();
    i_hsss_hpc_model.drive(2'h1, 2'h0);
    chk(MAIN_EN, 32'h0, "por out");
    apb(1'b0, 8'h00, 32'h0);
    chk(e, 32'h1, "por bus");
    repeat (PC + 4) @(posedge CLK);
    chk(MAIN_EN, 32'h0, "por edge");
    i_hsss_hpc_model.drive(2'h0, 2'h0);
    $display("test por done");
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(e, rows[i].err, "err");
      if (!rows[i].w) chk(q, rows[i].x, "read");
    end
    $display("test regs done");
    i_hsss_hpc_model.drive(2'h2, 2'h2);
    #1;
    chk({AUX_EN, MAIN_EN, GATE_PULLDN, DISCHARGE}, 32'he5, "pin on");
    MAIN_UV_OK <= 2'h1;
    repeat (3) @(posedge CLK);
    #1;
    chk({AUX_EN, MAIN_EN, SLOT_FAULT_N, INT_N}, 32'h62, "uv");
    apb(1'b0, 8'h0c, 32'h0);
    chk(q, 32'hd, "stat");
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h21, "standby");
    MAIN_UV_OK <= 2'h3;
    apb(1'b1, 8'h0c, 32'h1);
    @(posedge CLK);
    #1;
    chk(INT_N, 32'h1, "int clear");
    $display("test uv done");
    MAIN_UV_OK <= 2'h2;
    i_hsss_hpc_model.drive(2'h0, 2'h0);
    apb(1'b1, 8'h00, 32'h1);
    repeat (2) @(posedge CLK);
    #1;
    chk(MAIN_EN, 32'h0, "uv refuse");
    MAIN_UV_OK <= 2'h3;
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    #1;
    chk(MAIN_EN, 32'h1, "reg on");
    STBY_OK <= 1'b0;
    @(posedge CLK);
    STBY_OK <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk({e, MAIN_EN}, 32'h4, "restart");
    repeat (PC + 4) @(posedge CLK);
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0, "cleared");
    chk(e, 32'h0, "cleared err");
    $display("test register path done");
    SMI_STRAP_OFF <= 1'b1;
    rst();
    repeat (PC + 6) @(posedge CLK);
    apb(1'b0, 8'h10, 32'h0);
    chk(e, 32'h1, "strap");
    $display("test strap done");
    conclude();
  end
endmodule
`default_nettype wire
